// >>> rtl/nv_mem_ctrl.sv
`timescale 1ns/100ps
`include "nv_mem_defines.svh"

// Data EEPROM controller behind the special-function register port
module nv_mem_ctrl #(
	parameter int ADDR_W          = 10,
	parameter int PAGE_BYTES      = 16,
	parameter int ERASE_SHORT_CYC = `NV_ERASE_SHORT_NS / `NV_CLK_PERIOD_NS,
	parameter int WRITE_SHORT_CYC = `NV_WRITE_SHORT_NS / `NV_CLK_PERIOD_NS,
	parameter int ERASE_LONG_CYC  = `NV_ERASE_LONG_NS / `NV_CLK_PERIOD_NS,
	parameter int WRITE_LONG_CYC  = `NV_WRITE_LONG_NS / `NV_CLK_PERIOD_NS
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// Register port
	input  wire nv_mem_pkg::sfr_req_t  sfr_req,
	output logic [7:0]                 sfr_rdata,
	// Status
	output logic                       nv_busy
);

	localparam int IDX_W   = $clog2(PAGE_BYTES);
	localparam int TIMER_W = 24;
	localparam int DEPTH   = 1 << ADDR_W;

	nv_mem_pkg::ctrl_t     ctrl_reg;
	nv_mem_pkg::ctrl_t     ctrl_wr_val;
	nv_mem_pkg::nv_state_t state_reg;
	nv_mem_pkg::nv_op_t    op_reg;
	logic                  op_page_reg;
	logic [ADDR_W-1:0]     addr_reg;
	logic [7:0]            data_reg;
	logic [7:0]            rdata_reg;
	logic [7:0]            page_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] tag_reg;
	logic                  page_full_reg;
	logic                  wipe_en_d;
	logic                  prog_en_d;
	logic [TIMER_W-1:0]    timer_reg;
	logic [IDX_W-1:0]      idx_reg;
	logic                  sel_ctrl;
	logic                  sel_low;
	logic                  sel_high;
	logic                  sel_data;
	logic                  wr_ctrl;
	logic                  wr_low;
	logic                  wr_high;
	logic                  wr_data;
	logic                  page_data_wr;
	logic                  fetch_done;
	logic                  commit_last;
	logic                  erase_done;
	logic                  write_done;
	logic                  buf_clear;
	logic                  arr_wr_en;
	logic [ADDR_W-1:0]     arr_wr_addr;
	logic [7:0]            arr_wr_data;
	logic [7:0]            arr_rd_data;
	logic [7:0]            rd_mux;

	// Low nibble advances by one and sticks at the page end
	function automatic logic [ADDR_W-1:0] next_in_page(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] r;
		r = a;
		if (a[IDX_W-1:0] != {IDX_W{1'b1}})
		begin
			r[IDX_W-1:0] = a[IDX_W-1:0] + 1'b1;
		end
		return r;
	endfunction

	// Erase or write length in cycles, minus one, for the chosen timing
	function automatic logic [TIMER_W-1:0] cycle_len(input nv_mem_pkg::nv_op_t op,
		input logic slow);
		int n;
		if (op == nv_mem_pkg::OP_ERASE)
		begin
			n = slow ? ERASE_LONG_CYC : ERASE_SHORT_CYC;
		end
		else
		begin
			n = slow ? WRITE_LONG_CYC : WRITE_SHORT_CYC;
		end
		return TIMER_W'(n - 1);
	endfunction

	// Address decode; the array itself is never mapped
	assign sel_ctrl = sfr_req.sector && (sfr_req.addr == `NV_CTRL_OFS);
	assign sel_low  = !sfr_req.sector && (sfr_req.addr == `NV_ADDR_LOW_OFS);
	assign sel_high = !sfr_req.sector && (sfr_req.addr == `NV_ADDR_HIGH_OFS);
	assign sel_data = !sfr_req.sector && (sfr_req.addr == `NV_DATA_OFS);
	assign wr_ctrl  = sfr_req.wr && sel_ctrl;
	assign wr_low   = sfr_req.wr && sel_low;
	assign wr_high  = sfr_req.wr && sel_high;
	assign wr_data  = sfr_req.wr && sel_data;

	// Data writes in page mode feed the buffer until the page end is used
	assign page_data_wr = wr_data && ctrl_reg.page_mode && !page_full_reg;

	// Completion strobes from the sequencer
	assign fetch_done  = (state_reg == nv_mem_pkg::ST_FETCH) && (timer_reg == '0);
	assign commit_last = (state_reg == nv_mem_pkg::ST_COMMIT)
		&& (!op_page_reg || (idx_reg == IDX_W'(PAGE_BYTES - 1)));
	assign erase_done  = commit_last && (op_reg == nv_mem_pkg::OP_ERASE);
	assign write_done  = commit_last && (op_reg == nv_mem_pkg::OP_WRITE);

	// Buffer empties whenever the wipe or program enable falls from one to zero
	assign buf_clear = (wipe_en_d && !ctrl_reg.wipe_enable)
		|| (prog_en_d && !ctrl_reg.program_enable);

	// A trigger written while its enable is low is dropped
	always_comb
	begin
		ctrl_wr_val = nv_mem_pkg::ctrl_t'(sfr_req.wdata);
		ctrl_wr_val.wipe_go    = ctrl_wr_val.wipe_go && ctrl_reg.wipe_enable;
		ctrl_wr_val.program_go = ctrl_wr_val.program_go && ctrl_reg.program_enable;
		ctrl_wr_val.fetch_go   = ctrl_wr_val.fetch_go && ctrl_reg.fetch_enable;
	end

	// Control register; a software write in the clearing cycle wins
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_reg <= nv_mem_pkg::ctrl_t'(`NV_CTRL_RST);
		end
		else if (wr_ctrl)
		begin
			ctrl_reg <= ctrl_wr_val;
		end
		else
		begin
			if (erase_done)
			begin
				ctrl_reg.wipe_go     <= 1'b0;
				ctrl_reg.wipe_enable <= 1'b0;
			end
			if (write_done)
			begin
				ctrl_reg.program_go     <= 1'b0;
				ctrl_reg.program_enable <= 1'b0;
			end
			if (fetch_done)
			begin
				ctrl_reg.fetch_go <= 1'b0;
			end
		end
	end

	// Previous enables, for falling-edge detection
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wipe_en_d <= 1'b0;
			prog_en_d <= 1'b0;
		end
		else
		begin
			wipe_en_d <= ctrl_reg.wipe_enable;
			prog_en_d <= ctrl_reg.program_enable;
		end
	end

	// Array address: page bits stay, low nibble auto-advances
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			addr_reg <= '0;
		end
		else if (wr_low)
		begin
			addr_reg[7:0] <= sfr_req.wdata;
		end
		else if (wr_high)
		begin
			addr_reg[ADDR_W-1:8] <= sfr_req.wdata[ADDR_W-9:0];
		end
		else if (fetch_done && op_page_reg)
		begin
			addr_reg <= next_in_page(addr_reg);
		end
		else if (page_data_wr)
		begin
			addr_reg <= next_in_page(addr_reg);
		end
	end

	// Once the last slot of the page is filled, further data writes skip the buffer until an address write
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			page_full_reg <= 1'b0;
		end
		else if (wr_low || wr_high)
		begin
			page_full_reg <= 1'b0;
		end
		else if (page_data_wr && (addr_reg[IDX_W-1:0] == {IDX_W{1'b1}}))
		begin
			page_full_reg <= 1'b1;
		end
	end

	// Data port: loaded by software or by a finished read, else held
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			data_reg <= `NV_DATA_RST;
		end
		else if (wr_data)
		begin
			data_reg <= sfr_req.wdata;
		end
		else if (fetch_done)
		begin
			data_reg <= arr_rd_data;
		end
	end

	// Page buffer with a tag per slot marking bytes to program
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tag_reg <= '0;
			for (int i = 0; i < PAGE_BYTES; i++)
			begin
				page_buf[i] <= 8'h00;
			end
		end
		else if (buf_clear)
		begin
			tag_reg <= '0;
			for (int i = 0; i < PAGE_BYTES; i++)
			begin
				page_buf[i] <= 8'h00;
			end
		end
		else if (page_data_wr)
		begin
			tag_reg[addr_reg[IDX_W-1:0]]  <= 1'b1;
			page_buf[addr_reg[IDX_W-1:0]] <= sfr_req.wdata;
		end
	end

	// Sequencer: erase beats write beats read when several are pending
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg   <= nv_mem_pkg::ST_IDLE;
			op_reg      <= nv_mem_pkg::OP_ERASE;
			op_page_reg <= 1'b0;
			timer_reg   <= '0;
			idx_reg     <= '0;
		end
		else
		begin
			case (state_reg)
				nv_mem_pkg::ST_IDLE:
				begin
					idx_reg     <= '0;
					op_page_reg <= ctrl_reg.page_mode;
					if (ctrl_reg.wipe_go && ctrl_reg.wipe_enable)
					begin
						op_reg    <= nv_mem_pkg::OP_ERASE;
						timer_reg <= cycle_len(nv_mem_pkg::OP_ERASE,
							ctrl_reg.cell_timing_select);
						state_reg <= nv_mem_pkg::ST_TIMING;
					end
					else if (ctrl_reg.program_go && ctrl_reg.program_enable)
					begin
						op_reg    <= nv_mem_pkg::OP_WRITE;
						timer_reg <= cycle_len(nv_mem_pkg::OP_WRITE,
							ctrl_reg.cell_timing_select);
						state_reg <= nv_mem_pkg::ST_TIMING;
					end
					else if (ctrl_reg.fetch_go && ctrl_reg.fetch_enable)
					begin
						timer_reg <= TIMER_W'(`NV_READ_CYCLES - 1);
						state_reg <= nv_mem_pkg::ST_FETCH;
					end
				end
				nv_mem_pkg::ST_FETCH:
				begin
					if (timer_reg == '0)
					begin
						state_reg <= nv_mem_pkg::ST_IDLE;
					end
					else
					begin
						timer_reg <= timer_reg - 1'b1;
					end
				end
				nv_mem_pkg::ST_TIMING:
				begin
					// Cells change only at the end so an early read sees old data
					if (timer_reg == '0)
					begin
						state_reg <= nv_mem_pkg::ST_COMMIT;
					end
					else
					begin
						timer_reg <= timer_reg - 1'b1;
					end
				end
				nv_mem_pkg::ST_COMMIT:
				begin
					if (commit_last)
					begin
						state_reg <= nv_mem_pkg::ST_IDLE;
					end
					else
					begin
						idx_reg <= idx_reg + 1'b1;
					end
				end
				default:
				begin
					state_reg <= nv_mem_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Commit: page erase clears the whole page, page write only tagged slots
	always_comb
	begin
		arr_wr_en   = 1'b0;
		arr_wr_addr = addr_reg;
		arr_wr_data = 8'h00;
		if (state_reg == nv_mem_pkg::ST_COMMIT)
		begin
			if (op_page_reg)
			begin
				arr_wr_addr = {addr_reg[ADDR_W-1:IDX_W], idx_reg};
				arr_wr_en   = (op_reg == nv_mem_pkg::OP_ERASE) || tag_reg[idx_reg];
				arr_wr_data = (op_reg == nv_mem_pkg::OP_ERASE) ? 8'h00 : page_buf[idx_reg];
			end
			else
			begin
				arr_wr_en   = 1'b1;
				arr_wr_data = (op_reg == nv_mem_pkg::OP_ERASE) ? 8'h00 : data_reg;
			end
		end
	end

	nv_cell_array #(
		.DEPTH  (DEPTH),
		.ADDR_W (ADDR_W)
	) u_cells (
		.sys_clk (sys_clk),
		.wr_en   (arr_wr_en),
		.wr_addr (arr_wr_addr),
		.wr_data (arr_wr_data),
		.rd_addr (addr_reg),
		.rd_data (arr_rd_data)
	);

	// Read-back mux; unused high address bits and unmapped offsets read zero
	always_comb
	begin
		rd_mux = 8'h00;
		if (sel_ctrl)
		begin
			rd_mux = ctrl_reg;
		end
		else if (sel_low)
		begin
			rd_mux = addr_reg[7:0];
		end
		else if (sel_high)
		begin
			rd_mux = {{(16 - ADDR_W){1'b0}}, addr_reg[ADDR_W-1:8]};
		end
		else if (sel_data)
		begin
			rd_mux = data_reg;
		end
	end

	// Read data registered one cycle after the strobe
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_reg <= 8'h00;
		end
		else if (sfr_req.rd)
		begin
			rdata_reg <= rd_mux;
		end
	end

	assign sfr_rdata = rdata_reg;
	assign nv_busy   = (state_reg != nv_mem_pkg::ST_IDLE);

endmodule

// >>> common/nv_mem_defines.svh
// Operation
// - 1024 by 8 store, reached only via registers
// - Ten-bit address; high register upper bits zero
// - Timing select picks erase and write durations
// - Erase needs enable; enable cleared when erase ends
// - Erase trigger accepted only with enable; self-clears
// - Mode bit selects byte or 16-byte page
// - Write needs enable; enable cleared when write ends
// - Write trigger accepted only with enable; self-clears
// - No array read while read enable clear
// - Read trigger accepted only with enable; self-clears
// - Byte read presents addressed byte in data port
// - Data port holds until next read or write
// - Page read clears trigger, presents, advances address
// - Page mode increments low nibble, saturates 0FH
// - Erased page reads back all zero
`ifndef NV_MEM_DEFINES_SVH
`define NV_MEM_DEFINES_SVH

// Register offsets; control sits in sector 1, the rest in sector 0
`define NV_CTRL_OFS        8'h40
`define NV_ADDR_LOW_OFS    8'h20
`define NV_ADDR_HIGH_OFS   8'h21
`define NV_DATA_OFS        8'h22

// Reset values
`define NV_CTRL_RST        8'h00
`define NV_ADDR_RST        8'h00
`define NV_DATA_RST        8'h00

// Control field positions
`define NV_BIT_TIMING_SEL  7
`define NV_BIT_WIPE_EN     6
`define NV_BIT_WIPE_GO     5
`define NV_BIT_PAGE_MODE   4
`define NV_BIT_PROG_EN     3
`define NV_BIT_PROG_GO     2
`define NV_BIT_FETCH_EN    1
`define NV_BIT_FETCH_GO    0

// Timing, in nanoseconds, the clock period, and the read length in cycles
`define NV_CLK_PERIOD_NS   4
`define NV_ERASE_SHORT_NS  3200000
`define NV_WRITE_SHORT_NS  2200000
`define NV_ERASE_LONG_NS   3700000
`define NV_WRITE_LONG_NS   3000000
`define NV_READ_CYCLES     2

`endif

// >>> common/nv_mem_pkg.sv
package nv_mem_pkg;

	// Register port request from the core, one cycle per access
	typedef struct packed {
		logic       sector;
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_t;

	// Control register layout, bit 7 first
	typedef struct packed {
		logic cell_timing_select;
		logic wipe_enable;
		logic wipe_go;
		logic page_mode;
		logic program_enable;
		logic program_go;
		logic fetch_enable;
		logic fetch_go;
	} ctrl_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_TIMING,
		ST_COMMIT
	} nv_state_t;

	typedef enum logic {
		OP_ERASE,
		OP_WRITE
	} nv_op_t;

endpackage

// >>> rtl/nv_cell_array.sv
`timescale 1ns/100ps

// Cell array: one write port, registered read port
module nv_cell_array #(
	parameter int DEPTH  = 1024,
	parameter int ADDR_W = 10
) (
	// Clock
	input  wire logic              sys_clk,
	// Write port
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [7:0]        wr_data,
	// Read port
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [7:0]        rd_data
);

	logic [7:0] cells [DEPTH];

	// Contents survive reset, as a non-volatile store should
	always_ff @(posedge sys_clk)
	begin
		if (wr_en)
		begin
			cells[wr_addr] <= wr_data;
		end
	end

	// Read data is one cycle behind its address
	always_ff @(posedge sys_clk)
	begin
		rd_data <= cells[rd_addr];
	end

endmodule

// >>> test/nv_mem_ctrl_assertions.sv
`timescale 1ns/100ps

// Port-level checks on the register port and the busy timing
module nv_mem_ctrl_assertions #(
	parameter int ERASE_LONG_CYC = 925000
) (
	// Clock and reset
	input wire logic                 sys_clk,
	input wire logic                 rst,
	// Register port
	input wire nv_mem_pkg::sfr_req_t sfr_req,
	input wire logic [7:0]           sfr_rdata,
	// Status
	input wire logic                 nv_busy
);
	logic [31:0] busy_cnt;
	logic        s0_rd;
	logic        ctrl_wr;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// Length of the current busy run; a stuck sequence shows as overflow
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			busy_cnt <= 32'h0;
		else
			busy_cnt <= nv_busy ? busy_cnt + 32'h1 : 32'h0;

	// Decode of taken accesses
	assign s0_rd   = sfr_req.rd && !sfr_req.sector;
	assign ctrl_wr = sfr_req.wr && sfr_req.sector && sfr_req.addr == 8'h40;

	// Address write, then its read-back while idle
	sequence addr_set(logic [7:0] a);
		sfr_req.wr && !sfr_req.sector && sfr_req.addr == a && !nv_busy;
	endsequence
	sequence addr_get(logic [7:0] a);
		s0_rd && sfr_req.addr == a && !sfr_req.wr && !nv_busy;
	endsequence

	a_rdata_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (sfr_req.rd && (sfr_req.sector ? sfr_req.addr != 8'h40 :
		!(sfr_req.addr inside {[8'h20:8'h22]})) |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_high_upper_zero: assert property (s0_rd && sfr_req.addr == 8'h21 |=>
		sfr_rdata[7:2] == 6'h00) else $error("high address upper bits set");
	a_low_readback: assert property (addr_set(8'h20) ##2 addr_get(8'h20) |=>
		sfr_rdata == $past(sfr_req.wdata, 3)) else $error("low address read-back");
	a_high_readback: assert property (addr_set(8'h21) ##2 addr_get(8'h21) |=>
		sfr_rdata[1:0] == $past(sfr_req.wdata[1:0], 3)) else $error("high address read-back");
	a_fetch_min: assert property ($rose(nv_busy) |-> nv_busy[*2])
		else $error("busy shorter than a fetch");
	a_busy_bound: assert property (busy_cnt <= ERASE_LONG_CYC + 32)
		else $error("busy run too long");
	a_busy_cause: assert property ($rose(nv_busy) |->
		$past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
		else $error("busy without a control write");
endmodule

bind nv_mem_ctrl nv_mem_ctrl_assertions #(.ERASE_LONG_CYC(ERASE_LONG_CYC)) u_chk (
	.sys_clk   (sys_clk),
	.rst       (rst),
	.sfr_req   (sfr_req),
	.sfr_rdata (sfr_rdata),
	.nv_busy   (nv_busy)
);

// >>> test/tb.sv
`timescale 1ns/100ps

// Register-level bench for the data store controller
module tb;
	// Short cycle counts, far enough apart to tell the two timings apart
	localparam int ES = 20;
	localparam int WS = 15;
	localparam int EL = 40;
	localparam int WL = 35;
	localparam logic [7:0] GO [3] = '{8'h20, 8'h04, 8'h01};

	logic                 sys_clk;
	logic                 rst;
	nv_mem_pkg::sfr_req_t sfr_req;
	logic [7:0]           sfr_rdata;
	logic                 nv_busy;
	logic [7:0]           mem [1024];
	logic [7:0]           t;
	logic [9:0]           a;
	int                   error_cnt;
	int                   compares;

	nv_mem_ctrl #(
		.ERASE_SHORT_CYC (ES),
		.WRITE_SHORT_CYC (WS),
		.ERASE_LONG_CYC  (EL),
		.WRITE_LONG_CYC  (WL)
	) u_dut (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.sfr_req   (sfr_req),
		.sfr_rdata (sfr_rdata),
		.nv_busy   (nv_busy)
	);

	// Clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic complete_run();
		$display("compares %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Page slot after i steps; the low nibble stops at F
	function automatic logic [9:0] slot(input logic [9:0] b, input int i);
		return {b[9:4], (int'(b[3:0]) + i > 15) ? 4'hF : b[3:0] + 4'(i)};
	endfunction

	// One access; an idle cycle between accesses keeps each strobe a single pulse
	task automatic acc(input logic s, input logic [7:0] ad, input logic w, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_req = '{sector: s, addr: ad, wr: w, rd: !w, wdata: d};
		@(negedge sys_clk);
		sfr_req.wr = 1'b0;
		sfr_req.rd = 1'b0;
	endtask

	task automatic rdx(input logic s, input logic [7:0] ad, input logic [7:0] exp, input string nm);
		acc(s, ad, 1'b0, 8'h00);
		check(nm, sfr_rdata, exp);
	endtask

	task automatic setaddr(input logic [9:0] b);
		acc(1'b0, 8'h20, 1'b1, b[7:0]);
		acc(1'b0, 8'h21, 1'b1, {6'h00, b[9:8]});
	endtask

	// Enable, then trigger, then time the busy run and check the self-clear
	task automatic op(input logic [7:0] en, input logic [7:0] go, input int lo);
		int c;
		c = 0;
		acc(1'b1, 8'h40, 1'b1, en);
		// Slow clock is taken as settled here; only the trigger rises now
		acc(1'b1, 8'h40, 1'b1, en | go);
		while (nv_busy !== 1'b1 && c < 8)
		begin
			@(negedge sys_clk);
			c++;
		end
		c = 0;
		while (nv_busy === 1'b1 && c < 99)
		begin
			@(negedge sys_clk);
			c++;
		end
		check("busy span", {7'h00, c >= lo && c <= lo + 19}, 8'h01);
		rdx(1'b1, 8'h40, en & 8'hB7, "control");
	endtask

	// Fetch k bytes from b in page (m=1) or byte mode
	task automatic pread(input logic [9:0] b, input int k, input logic m);
		setaddr(b);
		for (int i = 0; i < k; i++)
		begin
			op(m ? 8'h12 : 8'h02, 8'h01, 2);
			rdx(1'b0, 8'h22, mem[slot(b, i)], "fetched data");
		end
	endtask

	// Page fill of n bytes from b; bytes past slot F are dropped
	task automatic pfill(input logic [9:0] b, input int n, input logic keep);
		logic [7:0] d;
		logic [9:0] e;
		setaddr(b);
		for (int i = 0; i < n; i++)
		begin
			d = 8'($urandom);
			acc(1'b0, 8'h22, 1'b1, d);
			if (keep && int'(b[3:0]) + i < 16)
				mem[slot(b, i)] = d;
		end
		// Low nibble only moves in page mode, so n is zero outside it
		e = slot(b, n);
		rdx(1'b0, 8'h20, e[7:0], "low address");
	endtask

	// Hang guard, far beyond the expected few thousand nanoseconds
	initial
	begin
		#200000;
		error_cnt++;
		complete_run();
	end

	initial
	begin
		error_cnt = 0;
		compares = 0;
		rst = 1'b1;
		sfr_req = '0;
		void'($urandom(99));
		repeat (8) @(negedge sys_clk);
		rst = 1'b0;
		for (int i = 0; i < 3; i++)
			rdx(1'b0, 8'h20 + 8'(i), 8'h00, "reset value");
		rdx(1'b1, 8'h40, 8'h00, "control reset");
		rdx(1'b0, 8'h23, 8'h00, "unmapped");
		rdx(1'b1, 8'h41, 8'h00, "unmapped");
		$display("test reset done");
		// Trigger without its enable must stay clear and start nothing
		foreach (GO[i])
		begin
			acc(1'b1, 8'h40, 1'b1, GO[i]);
			repeat (4) @(negedge sys_clk);
			check("idle busy", {7'h00, nv_busy}, 8'h00);
			rdx(1'b1, 8'h40, 8'h00, "refused trigger");
		end
		rdx(1'b0, 8'h22, 8'h00, "data after refusal");
		$display("test refusal done");
		setaddr(10'($urandom) | 10'h3FC);
		rdx(1'b0, 8'h21, 8'h03, "high address");
		$display("test address done");
		// Byte write then byte read, top address first, random timing select
		for (int i = 0; i < 3; i++)
		begin
			a = (i == 0) ? 10'h3FF : 10'($urandom);
			t = ($urandom % 2) ? 8'h80 : 8'h00;
			pfill(a, 0, 1'b0);
			mem[a] = 8'($urandom);
			acc(1'b0, 8'h22, 1'b1, mem[a]);
			op(t | 8'h08, 8'h04, (t != 8'h00) ? WL : WS);
			pread(a, 1, 1'b0);
			acc(1'b0, 8'h20, 1'b1, 8'h5A);
			rdx(1'b0, 8'h20, 8'h5A, "low readback");
			rdx(1'b0, 8'h22, mem[a], "held data");
		end
		$display("test byte done");
		// Page erase, page read of zeros, page write near the end, saturating read
		a = {6'($urandom), 4'h0};
		t = ($urandom % 2) ? 8'h80 : 8'h00;
		acc(1'b1, 8'h40, 1'b1, t | 8'h10);
		pfill(a, 16, 1'b0);
		op(t | 8'h50, 8'h20, (t != 8'h00) ? EL : ES);
		for (int i = 0; i < 16; i++)
			mem[a + 10'(i)] = 8'h00;
		pread(a, 16, 1'b1);
		rdx(1'b0, 8'h20, {a[7:4], 4'hF}, "page end");
		pfill(a | 10'h00C, 5, 1'b1);
		op(8'h18, 8'h04, WS);
		pread(a | 10'h00B, 6, 1'b1);
		// Byte erase at the saturated slot, then read it back in byte mode
		op(8'h40, 8'h20, ES);
		mem[a | 10'h00F] = 8'h00;
		pread(a | 10'h00F, 1, 1'b0);
		$display("test page done");
		complete_run();
	end
endmodule
